// ---- sim/calibration_command_filter_cfg_tb.sv ----
`timescale 1ns/100ps
module calibration_command_filter_cfg_tb;
   reg sys_clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg [1:0] module_sel_i = 2'h1;
   reg signed [15:0] raw_sample_i = 16'sh0064;
   wire iv, rv, nvw, rsv, fen, fsec;
   wire [7:0] b0, b1, b2, b3, cmd, rh, rl, st;
   wire [15:0] nvo, nvg, word;
   wire [2:0] rql, rsl;
   wire [3:0] fcut;
   reg [15:0] g;
   reg [7:0] code;
   integer n_errors = 0;
   integer tests_run = 0;
   integer i;
   always #2 sys_clk_i = ~sys_clk_i;
   ccf_master_model u_m (.sys_clk_i(sys_clk_i), .init_valid_o(iv), .init_b0_o(b0), .init_b1_o(b1), .init_b2_o(b2),
      .init_b3_o(b3), .req_valid_o(rv), .cmd_o(cmd), .ref_hi_o(rh), .ref_lo_o(rl));
   ccf_calib DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .init_valid_i(iv), .init_byte0_i(b0), .init_byte1_i(b1),
      .init_byte2_i(b2), .init_byte3_i(b3), .module_sel_i(module_sel_i), .req_valid_i(rv), .command_byte_i(cmd),
      .ref_hi_i(rh), .ref_lo_i(rl), .sample_valid_i(1'b1), .raw_sample_i(raw_sample_i), .nv_offset_i(16'h0000),
      .nv_gain_i(16'h0000), .nv_load_i(1'b0), .nv_write_o(nvw), .nv_offset_o(nvo), .nv_gain_o(nvg),
      .resp_valid_o(rsv), .status_code_byte_o(st), .measured_feedback_word_o(word), .req_len_o(rql),
      .resp_len_o(rsl), .filter_en_o(fen), .filter_second_o(fsec), .filter_cut_o(fcut));
   task chk(input [8*16-1:0] name, input [15:0] exp, input [15:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD %0s exp %h got %h", name, exp, got);
         end
      end
   endtask
   task finish_test;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, n_errors);
         if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task get_resp(input [7:0] exp_st);
      integer k;
      begin
         // The response stands 1 ns after the edge the caller returned on
         #1;
         for (k = 0; k < 64 && rsv !== 1'b1; k = k + 1) begin
            @(posedge sys_clk_i);
            #1;
         end
         if (k == 64) begin
            n_errors = n_errors + 1;
            finish_test;
         end else begin
            chk("status", {8'h00, exp_st}, {8'h00, st});
         end
      end
   endtask
   task set_sample(input [15:0] v);
      begin
         @(posedge sys_clk_i);
         raw_sample_i <= v;
         repeat (4) @(posedge sys_clk_i);
      end
   endtask
   task t_offset;
      begin
         u_m.send_req(8'h25, 16'h0000);
         u_m.send_req(8'h00, 16'h0000);
         get_resp(8'h25);
         chk("ofs_word", 16'h0064, word);
         chk("ofs_nv", 16'h0064, nvo);
         u_m.send_req(8'h00, 16'h0000);
         get_resp(8'h00);
         chk("zeroed", 16'h0000, word);
         $display("test offset done");
      end
   endtask
   task t_gain;
      begin
         u_m.send_req(8'h2B, 16'h1234);
         u_m.send_req(8'h00, 16'h0000);
         get_resp(8'h2B);
         chk("gain_word", 16'h1234, word);
         chk("gain_nv", 16'h1234, nvg);
         set_sample(16'h012C);
         u_m.send_req(8'h2D, 16'h0032);
         repeat (40) @(posedge sys_clk_i);
         u_m.send_req(8'h00, 16'h0000);
         get_resp(8'h2D);
         chk("cal_word", 16'h048D, word);
         chk("cal_nv", 16'h048D, nvg);
         $display("test gain done");
      end
   endtask
   task t_mode;
      begin
         g = nvg;
         @(posedge sys_clk_i);
         module_sel_i <= 2'h2;
         u_m.send_req(8'h2B, 16'h0055);
         u_m.send_req(8'h00, 16'h0000);
         get_resp(8'h00);
         chk("mode_gain", g, nvg);
         chk("req_len", 16'h0000, {13'h0000, rql});
         chk("resp_len", 16'h0003, {13'h0000, rsl});
         @(posedge sys_clk_i);
         module_sel_i <= 2'h3;
         repeat (2) @(posedge sys_clk_i);
         #1;
         chk("resp_len_w", 16'h0004, {13'h0000, rsl});
         @(posedge sys_clk_i);
         module_sel_i <= 2'h1;
         $display("test mode done");
      end
   endtask
   task t_init;
      begin
         set_sample(16'h0096);
         g = nvg;
         u_m.send_init(8'h01, 8'h00, 8'h64, 8'h00);
         repeat (40) @(posedge sys_clk_i);
         chk("init_ofs", 16'h0096, nvo);
         chk("prio_gain", g, nvg);
         set_sample(16'h00FA);
         u_m.send_init(8'h00, 8'h00, 8'hC8, 8'h00);
         repeat (40) @(posedge sys_clk_i);
         chk("init_gain", 16'h091A, nvg);
         $display("test init done");
      end
   endtask
   task t_filter;
      begin
         for (i = 0; i < 15; i = i + 1) begin
            code = 8'h43 + (i - 1) % 7;
            if (i > 7)
               code[7] = 1'b1;
            if (i == 0)
               code = 8'h00;
            u_m.send_init(8'h00, 8'h00, 8'h00, code);
            #1;
            chk("flt_en", {15'h0000, code != 8'h00}, {15'h0000, fen});
            if (code != 8'h00) begin
               chk("flt_ord", {15'h0000, code[7]}, {15'h0000, fsec});
               chk("flt_cut", {12'h000, 4'hC - code[3:0]}, {12'h000, fcut});
            end
         end
         $display("test filter done");
      end
   endtask
   initial begin
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      // Let the sample reach the calibration stage before the first request
      repeat (4) @(posedge sys_clk_i);
      #1;
      chk("req_len0", 16'h0003, {13'h0000, rql});
      t_offset;
      t_gain;
      t_mode;
      t_init;
      t_filter;
      finish_test;
   end
endmodule // calibration_command_filter_cfg_tb

// ---- sim/ccf_calib_assertions.sv ----
`timescale 1ns/100ps
module ccf_calib_chk (
   // Clock and reset
   input wire sys_clk_i,
   input wire rst_i,
   // Watched ports
   input wire init_valid_i,
   input wire [7:0] init_byte3_i,
   input wire [1:0] module_sel_i,
   input wire req_valid_i,
   input wire nv_load_i,
   input wire nv_write_o,
   input wire [15:0] nv_offset_o,
   input wire [15:0] nv_gain_o,
   input wire resp_valid_o,
   input wire [7:0] status_code_byte_o,
   input wire [15:0] measured_feedback_word_o,
   input wire [2:0] req_len_o,
   input wire filter_en_o,
   input wire filter_second_o,
   input wire [3:0] filter_cut_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   a_resp_after_req: assert property (resp_valid_o |-> $past(req_valid_i))
      else $error("response without request");
   a_len_by_mode: assert property ($stable(module_sel_i) |-> req_len_o == ((module_sel_i == 2'h1) ? 3'h3 : 3'h0))
      else $error("request length wrong");
   a_mode_refuse: assert property (resp_valid_o && $past(module_sel_i) != 2'h1 |-> status_code_byte_o == 8'h00)
      else $error("command served outside full control");
   a_offset_echo: assert property (resp_valid_o && status_code_byte_o == 8'h25 |-> measured_feedback_word_o == nv_offset_o)
      else $error("offset response word wrong");
   a_gain_echo: assert property (resp_valid_o && status_code_byte_o == 8'h2B |-> measured_feedback_word_o == nv_gain_o)
      else $error("gain response word wrong");
   a_nv_store: assert property (!$past(nv_load_i) && ($changed(nv_offset_o) || $changed(nv_gain_o)) |-> nv_write_o)
      else $error("calibration not stored");
   a_filter_off: assert property (init_valid_i && init_byte3_i == 8'h00 |=> !filter_en_o)
      else $error("filter not disabled");
   a_filter_code: assert property (init_valid_i && init_byte3_i[6:0] >= 7'h43 && init_byte3_i[6:0] <= 7'h49
      |=> filter_en_o && filter_second_o == $past(init_byte3_i[7]) && filter_cut_o == 4'hC - $past(init_byte3_i[3:0]))
      else $error("filter setting decode wrong");
   c_offset: cover property (resp_valid_o && status_code_byte_o == 8'h25);
   c_gain: cover property (resp_valid_o && status_code_byte_o == 8'h2B);
   c_second: cover property (filter_en_o && filter_second_o);
   c_cal: cover property (resp_valid_o && status_code_byte_o == 8'h2D);
endmodule // ccf_calib_chk
bind ccf_calib ccf_calib_chk u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .init_valid_i(init_valid_i),
   .init_byte3_i(init_byte3_i), .module_sel_i(module_sel_i), .req_valid_i(req_valid_i), .nv_load_i(nv_load_i),
   .nv_write_o(nv_write_o), .nv_offset_o(nv_offset_o), .nv_gain_o(nv_gain_o), .resp_valid_o(resp_valid_o),
   .status_code_byte_o(status_code_byte_o), .measured_feedback_word_o(measured_feedback_word_o),
   .req_len_o(req_len_o), .filter_en_o(filter_en_o), .filter_second_o(filter_second_o), .filter_cut_o(filter_cut_o));

// ---- sim/ccf_master_model.sv ----
`timescale 1ns/100ps
module ccf_master_model (
   // Clock
   input wire sys_clk_i,
   // Parameter telegram
   output reg init_valid_o = 1'b0,
   output reg [7:0] init_b0_o = 8'h00,
   output reg [7:0] init_b1_o = 8'h00,
   output reg [7:0] init_b2_o = 8'h00,
   output reg [7:0] init_b3_o = 8'h00,
   // Cyclic request
   output reg req_valid_o = 1'b0,
   output reg [7:0] cmd_o = 8'h00,
   output reg [7:0] ref_hi_o = 8'h00,
   output reg [7:0] ref_lo_o = 8'h00
);
   task send_init(input [7:0] b0, input [7:0] b1, input [7:0] b2, input [7:0] b3);
      begin
         @(posedge sys_clk_i);
         init_valid_o <= 1'b1;
         {init_b0_o, init_b1_o, init_b2_o, init_b3_o} <= {b0, b1, b2, b3};
         @(posedge sys_clk_i);
         init_valid_o <= 1'b0;
         {init_b0_o, init_b1_o, init_b2_o} <= 24'h000000;
      end
   endtask
   task send_req(input [7:0] cmd, input [15:0] word);
      begin
         @(posedge sys_clk_i);
         req_valid_o <= 1'b1;
         cmd_o <= cmd;
         {ref_hi_o, ref_lo_o} <= word;
         @(posedge sys_clk_i);
         req_valid_o <= 1'b0;
         {ref_hi_o, ref_lo_o} <= ~word;
      end
   endtask
endmodule // ccf_master_model

// ---- src/ccf_calib.v ----
`timescale 1ns/100ps
`include "ccf_regs.vh"
module ccf_calib (
   // Clock and reset
   input wire sys_clk_i,
   input wire rst_i,
   // Initial parameters
   input wire init_valid_i,
   input wire [7:0] init_byte0_i,
   input wire [7:0] init_byte1_i,
   input wire [7:0] init_byte2_i,
   input wire [7:0] init_byte3_i,
   // Configuration
   input wire [1:0] module_sel_i,
   // Cyclic request
   input wire req_valid_i,
   input wire [7:0] command_byte_i,
   input wire [7:0] ref_hi_i,
   input wire [7:0] ref_lo_i,
   // Measurement
   input wire sample_valid_i,
   input wire signed [15:0] raw_sample_i,
   // Nonvolatile store
   input wire [15:0] nv_offset_i,
   input wire [15:0] nv_gain_i,
   input wire nv_load_i,
   output reg nv_write_o,
   output reg [15:0] nv_offset_o,
   output reg [15:0] nv_gain_o,
   // Response
   output reg resp_valid_o,
   output reg [7:0] status_code_byte_o,
   output reg [15:0] measured_feedback_word_o,
   output reg [2:0] req_len_o,
   output reg [2:0] resp_len_o,
   // Filter state
   output reg filter_en_o,
   output reg filter_second_o,
   output reg [3:0] filter_cut_o
);
   // ************************************************************
   // Sequencer states and working registers
   // ************************************************************
   localparam ST_IDLE = 3'b001;
   localparam ST_GAIN = 3'b010;
   localparam ST_RESP = 3'b100;
   reg [2:0] state_q;
   reg [7:0] last_cmd_q;
   reg [7:0] last_b0_q;
   reg [15:0] last_gref_q;
   reg signed [15:0] offset_q;
   reg [15:0] gain_q;
   reg [7:0] pend_code_q;
   reg [15:0] gref_q;
   reg [31:0] quot_q;
   reg [31:0] rem_q;
   reg [15:0] div_q;
   reg [4:0] bit_q;
   reg pend_resp_q;
   reg signed [15:0] fsamp_q;
   wire signed [15:0] corr;
   wire signed [15:0] filt;
   wire signed [16:0] net;
   wire [15:0] ref_word;
   wire [15:0] init_gref;
   wire full_ctl;
   wire new_cmd;
   wire [31:0] prod;
   wire [31:0] scaled;
   wire [32:0] rem_try;
   wire [3:0] lo_nib;
   wire flt_valid;
   // ************************************************************
   // Field decode and arithmetic
   // ************************************************************
   assign ref_word = {ref_hi_i, ref_lo_i};
   assign init_gref = {init_byte1_i, init_byte2_i};
   assign full_ctl = (module_sel_i == `CCF_MOD_FULL);
   assign new_cmd = req_valid_i && full_ctl && (command_byte_i != last_cmd_q);
   assign net = {fsamp_q[15], fsamp_q} - {offset_q[15], offset_q};
   assign prod = $signed(net[15:0]) * $signed({1'b0, gain_q});
   assign scaled = prod >>> `CCF_GAIN_SHIFT;
   assign corr = scaled[15:0];
   assign lo_nib = init_byte3_i[3:0];
   assign flt_valid = (init_byte3_i[6:4] == `CCF_FLT_HI) && (lo_nib >= `CCF_FLT_LO_MIN) && (lo_nib <= `CCF_FLT_LO_MAX);
   assign rem_try = {rem_q[31:0], quot_q[31]} - {17'h0, div_q};
   // ************************************************************
   // Measurement filter
   // ************************************************************
   ccf_lowpass u_lp (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .enable_i(filter_en_o),
      .second_order_i(filter_second_o),
      .shift_i(filter_cut_o),
      .sample_valid_i(sample_valid_i),
      .sample_i(raw_sample_i),
      .filtered_o(filt)
   );
   // ************************************************************
   // Command sequencer
   // ************************************************************
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         last_cmd_q <= `CCF_CMD_NONE;
         last_b0_q <= 8'h00;
         last_gref_q <= 16'h0000;
         offset_q <= `CCF_OFS_RST;
         gain_q <= `CCF_GAIN_RST;
         pend_code_q <= `CCF_ST_OK;
         gref_q <= 16'h0000;
         quot_q <= 32'h00000000;
         rem_q <= 32'h00000000;
         div_q <= 16'h0001;
         bit_q <= 5'h00;
         pend_resp_q <= 1'b0;
         fsamp_q <= 16'h0000;
         nv_write_o <= 1'b0;
         nv_offset_o <= `CCF_OFS_RST;
         nv_gain_o <= `CCF_GAIN_RST;
         resp_valid_o <= 1'b0;
         status_code_byte_o <= `CCF_ST_OK;
         measured_feedback_word_o <= 16'h0000;
         req_len_o <= `CCF_LEN_FULL;
         resp_len_o <= `CCF_LEN_FULL;
         filter_en_o <= 1'b0;
         filter_second_o <= 1'b0;
         filter_cut_o <= `CCF_SHIFT_BASE;
      end else begin
         nv_write_o <= 1'b0;
         resp_valid_o <= 1'b0;
         if (sample_valid_i)
            fsamp_q <= filt;
         // Status modules carry no command byte or reference word
         req_len_o <= full_ctl ? `CCF_LEN_FULL : `CCF_LEN_STATUS;
         resp_len_o <= (module_sel_i == `CCF_MOD_STATUS_W) ? `CCF_LEN_STATUS_W : `CCF_LEN_FULL;
         if (req_valid_i)
            last_cmd_q <= full_ctl ? command_byte_i : `CCF_CMD_NONE;
         if (nv_load_i && state_q == ST_IDLE) begin
            offset_q <= nv_offset_i;
            gain_q <= nv_gain_i;
         end
         if (init_valid_i) begin
            last_b0_q <= init_byte0_i;
            last_gref_q <= init_gref;
            if (init_byte3_i == `CCF_FLT_OFF || !flt_valid) begin
               filter_en_o <= 1'b0;
            end else begin
               filter_en_o <= 1'b1;
               filter_second_o <= init_byte3_i[`CCF_FLT_ORD_BIT];
               filter_cut_o <= `CCF_SHIFT_BASE + (`CCF_FLT_LO_MAX - lo_nib);
            end
         end
         case (state_q)
            ST_IDLE: begin
               if (init_valid_i && init_byte0_i == `CCF_INIT_FIND && last_b0_q != `CCF_INIT_FIND) begin
                  offset_q <= fsamp_q;
                  nv_offset_o <= fsamp_q;
                  nv_gain_o <= gain_q;
                  nv_write_o <= 1'b1;
               end else if (init_valid_i && init_gref != 16'h0000 && init_gref != last_gref_q) begin
                  gref_q <= init_gref;
                  pend_resp_q <= 1'b0;
                  state_q <= ST_GAIN;
               end else if (new_cmd && command_byte_i == `CCF_CMD_FIND_OFS) begin
                  offset_q <= fsamp_q;
                  nv_offset_o <= fsamp_q;
                  nv_gain_o <= gain_q;
                  nv_write_o <= 1'b1;
                  pend_code_q <= `CCF_CMD_FIND_OFS;
                  measured_feedback_word_o <= fsamp_q;
                  state_q <= ST_RESP;
               end else if (new_cmd && command_byte_i == `CCF_CMD_WRITE_GAIN) begin
                  gain_q <= ref_word;
                  nv_offset_o <= offset_q;
                  nv_gain_o <= ref_word;
                  nv_write_o <= 1'b1;
                  pend_code_q <= `CCF_CMD_WRITE_GAIN;
                  measured_feedback_word_o <= ref_word;
                  state_q <= ST_RESP;
               end else if (new_cmd && command_byte_i == `CCF_CMD_CAL_GAIN && ref_word != 16'h0000) begin
                  gref_q <= ref_word;
                  pend_resp_q <= 1'b1;
                  state_q <= ST_GAIN;
               end else if (req_valid_i) begin
                  resp_valid_o <= 1'b1;
                  status_code_byte_o <= `CCF_ST_OK;
                  measured_feedback_word_o <= corr;
               end
               if (state_q == ST_IDLE) begin
                  // Dividend gref*gain, divisor current net reading
                  quot_q <= (init_valid_i ? init_gref : ref_word) * gain_q;
                  rem_q <= 32'h00000000;
                  div_q <= (net[15:0] == 16'h0000 || net[16]) ? 16'h0001 : net[15:0];
                  bit_q <= 5'h00;
               end
            end
            ST_GAIN: begin
               // Restoring divide, one quotient bit per cycle
               if (rem_try[32]) begin
                  rem_q <= {rem_q[30:0], quot_q[31]};
                  quot_q <= {quot_q[30:0], 1'b0};
               end else begin
                  rem_q <= rem_try[31:0];
                  quot_q <= {quot_q[30:0], 1'b1};
               end
               bit_q <= bit_q + 5'h01;
               if (bit_q == `CCF_DIV_LAST) begin
                  gain_q <= quot_q[14:0] == 15'h0 ? gain_q : {quot_q[14:0], ~rem_try[32]};
                  nv_offset_o <= offset_q;
                  nv_gain_o <= {quot_q[14:0], ~rem_try[32]};
                  nv_write_o <= 1'b1;
                  measured_feedback_word_o <= {quot_q[14:0], ~rem_try[32]};
                  pend_code_q <= `CCF_CMD_CAL_GAIN;
                  state_q <= pend_resp_q ? ST_RESP : ST_IDLE;
               end
            end
            ST_RESP: begin
               if (req_valid_i) begin
                  resp_valid_o <= 1'b1;
                  status_code_byte_o <= pend_code_q;
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule // ccf_calib

// ---- src/ccf_lowpass.v ----
`timescale 1ns/100ps
`include "ccf_regs.vh"
module ccf_lowpass (
   // Clock and reset
   input wire sys_clk_i,
   input wire rst_i,
   // Control
   input wire enable_i,
   input wire second_order_i,
   input wire [3:0] shift_i,
   input wire sample_valid_i,
   // Data
   input wire signed [15:0] sample_i,
   output reg signed [15:0] filtered_o
);
   reg signed [31:0] st1_q;
   reg signed [31:0] st2_q;
   wire signed [31:0] in_ext;
   wire signed [31:0] st1_d;
   wire signed [31:0] st2_d;
   assign in_ext = {sample_i, 16'h0000};
   // One-pole stages; the second cascaded for sharper roll-off
   assign st1_d = st1_q + ((in_ext - st1_q) >>> shift_i);
   assign st2_d = st2_q + ((st1_q - st2_q) >>> shift_i);
   always @(posedge sys_clk_i) begin
      if (rst_i) begin
         st1_q <= 32'h00000000;
         st2_q <= 32'h00000000;
         filtered_o <= 16'h0000;
      end else if (sample_valid_i) begin
         if (!enable_i) begin
            st1_q <= in_ext;
            st2_q <= in_ext;
            filtered_o <= sample_i;
         end else begin
            st1_q <= st1_d;
            st2_q <= st2_d;
            filtered_o <= second_order_i ? st2_d[31:16] : st1_d[31:16];
         end
      end
   end
endmodule // ccf_lowpass

// ---- src/ccf_regs.vh ----
`ifndef CCF_REGS_VH
`define CCF_REGS_VH
`define CCF_CMD_NONE 8'h00
`define CCF_CMD_FIND_OFS 8'h25
`define CCF_CMD_WRITE_GAIN 8'h2B
`define CCF_CMD_CAL_GAIN 8'h2D
`define CCF_ST_OK 8'h00
`define CCF_MOD_FULL 2'h1
`define CCF_MOD_STATUS 2'h2
`define CCF_MOD_STATUS_W 2'h3
`define CCF_LEN_FULL 3'h3
`define CCF_LEN_STATUS 3'h0
`define CCF_OFS_RST 16'h0000
`define CCF_GAIN_RST 16'h2710
`define CCF_NOMINAL 16'h2710
`define CCF_FLT_OFF 8'h00
`define CCF_FLT_ORD_BIT 7
`define CCF_FLT_LO_MIN 4'h3
`define CCF_FLT_LO_MAX 4'h9
`define CCF_FLT_MID 3'h2
`define CCF_SHIFT_BASE 4'h3
`define CCF_FLT_HI 3'h4
`define CCF_INIT_FIND 8'h01
`define CCF_LEN_STATUS_W 3'h4
`define CCF_GAIN_SHIFT 13
`define CCF_DIV_LAST 5'h1F
`endif
